//--- design/usf_baud.sv
`timescale 1ns/1ps
// ****************************************
// Oversampling tick generator
// ****************************************
module usf_baud (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] div,
    output logic             tick
);
    logic [15:0] cnt;

    // One tick every div clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt >= div - 16'h0001) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : usf_baud

//--- design/usf_pkg.sv
// How it works
// - Half-duplex only when select bit set
// - Half-duplex: ignore RX, loop TX to receiver
// - Word length: 0=8, 1=9, 2=7 bits
// - Parity replaces character MSB when enabled
// - Parity type: 0 even, 1 odd
// - Even parity bit makes ones count even
// - Receive parity failure sets parity error flag
// - Parity error interrupts when both enables on
// - Writing clear bit clears parity error
// - One or two stop bits
// - Enabled transmitter shifts data, drives clock; no clock in half-duplex
// - Characters go out LSB first
// - Data register buffers ahead of shifter
// - Low start bit, high stop bits
// - Enabled idle transmitter holds line high; in half-duplex it releases the line (tx_oe low)
// - Oversampling of 8 or 16
// - Bit rate up to 6 Mbit/s
// - Multiprocessor mute on mismatch, wake on idle/mark
// - Complete flag when frame done, buffer empty
package usf_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BAUD = 8'h04;
    localparam logic [7:0] OFF_STS  = 8'h08;
    localparam logic [7:0] OFF_CLR  = 8'h0C;
    localparam logic [7:0] OFF_TXD  = 8'h10;
    localparam logic [7:0] OFF_RXD  = 8'h14;
    localparam logic [7:0] OFF_ADDR = 8'h18;

    localparam int CLR_PE = 0;
    localparam int CLR_TC = 1;

    // ****************************************
    // Fields and reset values
    // ****************************************
    typedef struct packed {
        logic       mp_enable;
        logic       tc_irq_enable;
        logic       pe_irq_enable;
        logic       sync_clock_out_enable;
        logic       half_duplex_select;
        logic       os8;
        logic       stop_bit_count;
        logic [1:0] word_length_field;
        logic       parity_type;
        logic       parity_enable;
        logic       rx_enable;
        logic       transmitter_enable;
    } usf_ctrl_t;

    typedef struct packed {
        logic mute;
        logic rx_busy;
        logic tx_busy;
        logic rxne;
        logic parity_error_flag;
        logic tx_complete_flag;
        logic txe;
    } usf_sts_t;

    localparam logic [12:0] CTRL_RST = 13'h0000;
    localparam logic [15:0] BAUD_RST = 16'h0010;
    localparam logic        TC_RST   = 1'b1;

    localparam logic [1:0] WL_8 = 2'h0;
    localparam logic [1:0] WL_9 = 2'h1;
    localparam logic [1:0] WL_7 = 2'h2;

    localparam logic [3:0] OS8_LAST  = 4'h7;
    localparam logic [3:0] OS16_LAST = 4'hF;
    localparam logic [3:0] OS8_MID   = 4'h3;
    localparam logic [3:0] OS16_MID  = 4'h7;

    // ****************************************
    // Rate limit
    // ****************************************
    localparam int CLK_HZ      = 200_000_000;
    localparam int MAX_BPS     = 6_000_000;
    localparam int MIN_SAMPLES = 8;
    localparam int MIN_DIV_INT = (CLK_HZ + MAX_BPS * MIN_SAMPLES - 1) / (MAX_BPS * MIN_SAMPLES);
    localparam logic [15:0] BAUD_DIV_MIN = 16'(MIN_DIV_INT);

endpackage : usf_pkg

//--- design/usf_sync.sv
`timescale 1ns/1ps
// ****************************************
// Two-stage pin synchroniser
// ****************************************
module usf_sync #(
    parameter int W = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // Idle level of serial lines is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '1;
            q    <= '1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : usf_sync

//--- design/usf_top.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module usf_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        rx_pin,
    input  wire logic        tx_pin_in,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             tx_out,
    output logic             tx_oe,
    output logic             ck_out,
    output logic             ck_oe,
    output logic             irq
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] data_bits(input logic [1:0] wl);
        case (wl)
            usf_pkg::WL_9: data_bits = 4'h9;
            usf_pkg::WL_7: data_bits = 4'h7;
            default:       data_bits = 4'h8;
        endcase
    endfunction : data_bits

    function automatic logic [8:0] mask(input logic [3:0] n);
        mask = 9'h1FF >> (4'h9 - n);
    endfunction : mask

    function automatic logic [8:0] tx_word(input logic [8:0] d, input logic [3:0] n,
                                           input logic pen, input logic odd);
        logic [8:0] w;
        w = d & mask(n);
        if (pen) begin
            w[n - 4'h1] = (^(d & mask(n - 4'h1))) ^ odd;
        end
        tx_word = w;
    endfunction : tx_word

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == usf_pkg::OFF_CTRL) || (a == usf_pkg::OFF_BAUD) ||
                 (a == usf_pkg::OFF_STS)  || (a == usf_pkg::OFF_CLR)  ||
                 (a == usf_pkg::OFF_TXD)  || (a == usf_pkg::OFF_RXD)  ||
                 (a == usf_pkg::OFF_ADDR);
    endfunction : mapped

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usf_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usf_rx_t;

    usf_pkg::usf_ctrl_t ctrl;
    usf_pkg::usf_sts_t  sts;
    usf_tx_t            tstate;
    usf_rx_t            rstate;
    logic [15:0]        baud_div;
    logic [3:0]         own_addr;
    logic [8:0]         tdr;
    logic               tdr_full;
    logic               tc;
    logic               pe;
    logic               rxne;
    logic               mute;
    logic [8:0]         rdr;
    logic [8:0]         tsh;
    logic [8:0]         rsh;
    logic [3:0]         tos;
    logic [3:0]         ros;
    logic [3:0]         tbit;
    logic [3:0]         rbit;
    logic [3:0]         icnt;
    logic [31:0]        next_rdata;
    logic               next_tx;
    logic               tick;
    logic [1:0]         pins;

    // ****************************************
    // Bus decode
    // ****************************************
    wire       setup  = psel & ~penable;
    wire       acc    = psel & penable & pready;
    wire       wr     = acc & pwrite;
    wire       wr_txd = wr & (paddr == usf_pkg::OFF_TXD);
    wire       wr_clr = wr & (paddr == usf_pkg::OFF_CLR);
    wire       rd_rxd = acc & ~pwrite & (paddr == usf_pkg::OFF_RXD);
    wire [3:0] nbits  = data_bits(ctrl.word_length_field);
    wire [3:0] os_last = ctrl.os8 ? usf_pkg::OS8_LAST : usf_pkg::OS16_LAST;
    wire [3:0] os_mid  = ctrl.os8 ? usf_pkg::OS8_MID : usf_pkg::OS16_MID;
    wire       hd     = ctrl.half_duplex_select;

    // Divider floor keeps the bit rate at or below the limit
    wire [15:0] div_eff = (baud_div < usf_pkg::BAUD_DIV_MIN) ? usf_pkg::BAUD_DIV_MIN
                                                             : baud_div;

    // ****************************************
    // Submodules
    // ****************************************
    usf_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({tx_pin_in, rx_pin}),
        .q       (pins)
    );

    usf_baud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .div     (div_eff),
        .tick    (tick)
    );

    // Receiver source: looped TX pin in half-duplex, RX pin otherwise
    wire rx_line = hd ? pins[1] : pins[0];

    // ****************************************
    // APB slave
    // ****************************************
    // Status view
    always_comb begin
        sts.mute              = mute;
        sts.rx_busy           = (rstate != RX_IDLE);
        sts.tx_busy           = (tstate != TX_IDLE);
        sts.rxne              = rxne;
        sts.parity_error_flag = pe;
        sts.tx_complete_flag  = tc;
        sts.txe               = ~tdr_full;
    end

    // Read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr)
            usf_pkg::OFF_CTRL: next_rdata = {19'h0, ctrl};
            usf_pkg::OFF_BAUD: next_rdata = {16'h0, baud_div};
            usf_pkg::OFF_STS:  next_rdata = {25'h0, sts};
            usf_pkg::OFF_RXD:  next_rdata = {23'h0, rdr};
            usf_pkg::OFF_ADDR: next_rdata = {28'h0, own_addr};
            default:           next_rdata = 32'h0000_0000;
        endcase
    end

    // No wait state: answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped(paddr);
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= usf_pkg::CTRL_RST;
            baud_div <= usf_pkg::BAUD_RST;
            own_addr <= 4'h0;
        end else if (wr) begin
            if (paddr == usf_pkg::OFF_CTRL) begin
                ctrl <= pwdata[12:0];
            end
            if (paddr == usf_pkg::OFF_BAUD) begin
                baud_div <= pwdata[15:0];
            end
            if (paddr == usf_pkg::OFF_ADDR) begin
                own_addr <= pwdata[3:0];
            end
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    wire ten     = ctrl.transmitter_enable;
    wire tx_load = ten & (tstate == TX_IDLE) & tdr_full;
    wire btick   = tick & (tos == os_last);
    wire tx_done = (tstate == TX_STOP) & btick & (tbit == {3'h0, ctrl.stop_bit_count});

    // Buffer between bus and shifter; a write always wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tdr      <= 9'h000;
            tdr_full <= 1'b0;
        end else if (wr_txd) begin
            tdr      <= pwdata[8:0];
            tdr_full <= 1'b1;
        end else if (tx_load) begin
            tdr_full <= 1'b0;
        end
    end

    // Frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tstate <= TX_IDLE;
            tsh    <= 9'h000;
            tos    <= 4'h0;
            tbit   <= 4'h0;
        end else if (!ten) begin
            tstate <= TX_IDLE;
            tos    <= 4'h0;
        end else begin
            tos <= (tick && tos != os_last) ? tos + 4'h1 : (tick ? 4'h0 : tos);
            case (tstate)
                TX_IDLE: begin
                    if (tdr_full) begin
                        tsh    <= tx_word(tdr, nbits, ctrl.parity_enable,
                                          ctrl.parity_type);
                        tstate <= TX_START;
                        tos    <= 4'h0;
                        tbit   <= 4'h0;
                    end
                end
                TX_START: begin
                    if (btick) begin
                        tstate <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (btick) begin
                        tsh  <= {1'b0, tsh[8:1]};
                        tbit <= tbit + 4'h1;
                        if (tbit == nbits - 4'h1) begin
                            tstate <= TX_STOP;
                            tbit   <= 4'h0;
                        end
                    end
                end
                TX_STOP: begin
                    if (btick) begin
                        tbit <= tbit + 4'h1;
                        if (tx_done) begin
                            tstate <= TX_IDLE;
                        end
                    end
                end
                default: tstate <= TX_IDLE;
            endcase
        end
    end

    // Line level per state
    always_comb begin
        case (tstate)
            TX_START: next_tx = 1'b0;
            TX_DATA:  next_tx = tsh[0];
            default:  next_tx = 1'b1;
        endcase
    end

    // Pins; half-duplex drives low only, clock only outside half-duplex
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_out <= 1'b1;
            tx_oe  <= 1'b0;
            ck_out <= 1'b0;
            ck_oe  <= 1'b0;
        end else begin
            tx_out <= next_tx;
            tx_oe  <= ten & (hd ? ~next_tx : 1'b1);
            ck_oe  <= ctrl.sync_clock_out_enable & ~hd;
            ck_out <= ctrl.sync_clock_out_enable & ~hd & (tstate == TX_DATA)
                      & (tos > os_mid);
        end
    end

    // Complete flag; a set in the clearing cycle wins
    wire tc_set = tx_done & ~tdr_full & ~wr_txd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc <= usf_pkg::TC_RST;
        end else if (tc_set) begin
            tc <= 1'b1;
        end else if (wr_txd || (wr_clr && pwdata[usf_pkg::CLR_TC])) begin
            tc <= 1'b0;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    wire       rx_done = (rstate == RX_STOP) & tick & (ros == os_last);
    wire       mark    = rsh[nbits - 4'h1];
    wire       match   = (rsh[3:0] == own_addr);
    wire       accept  = ~ctrl.mp_enable | (mark ? match : ~mute);
    wire       par_bad = ctrl.parity_enable & ((^(rsh & mask(nbits))) ^ ctrl.parity_type);
    wire       idle_hit = (icnt == nbits + 4'h2) & tick & (ros == os_last);

    // Frame capture at bit centres
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rstate <= RX_IDLE;
            rsh    <= 9'h000;
            ros    <= 4'h0;
            rbit   <= 4'h0;
            icnt   <= 4'h0;
        end else if (!ctrl.rx_enable) begin
            rstate <= RX_IDLE;
            ros    <= 4'h0;
            icnt   <= 4'h0;
        end else begin
            if (tick) begin
                ros <= (ros == os_last) ? 4'h0 : ros + 4'h1;
            end
            case (rstate)
                RX_IDLE: begin
                    if (!rx_line) begin
                        rstate <= RX_START;
                        ros    <= 4'h0;
                        icnt   <= 4'h0;
                    end else if (tick && ros == os_last && icnt != 4'hF) begin
                        icnt <= icnt + 4'h1;
                    end
                end
                RX_START: begin
                    if (tick && ros == os_mid) begin
                        rstate <= rx_line ? RX_IDLE : RX_DATA;
                        ros    <= 4'h0;
                        rbit   <= 4'h0;
                        rsh    <= 9'h000;
                    end
                end
                RX_DATA: begin
                    if (tick && ros == os_last) begin
                        rsh[rbit] <= rx_line;
                        rbit      <= rbit + 4'h1;
                        if (rbit == nbits - 4'h1) begin
                            rstate <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_done) begin
                        rstate <= RX_IDLE;
                    end
                end
                default: rstate <= RX_IDLE;
            endcase
        end
    end

    // Multiprocessor mute
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mute <= 1'b0;
        end else if (!ctrl.mp_enable) begin
            mute <= 1'b0;
        end else if (rx_done && mark) begin
            mute <= ~match;
        end else if (idle_hit) begin
            mute <= 1'b0;
        end
    end

    // Received data and flags; sets win over clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdr  <= 9'h000;
            rxne <= 1'b0;
            pe   <= 1'b0;
        end else begin
            if (rx_done && accept) begin
                rdr  <= rsh & mask(nbits);
                rxne <= 1'b1;
            end else if (rd_rxd) begin
                rxne <= 1'b0;
            end
            if (rx_done && accept && par_bad) begin
                pe <= 1'b1;
            end else if (wr_clr && pwdata[usf_pkg::CLR_PE]) begin
                pe <= 1'b0;
            end
        end
    end

    // Interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (pe & ctrl.pe_irq_enable & ctrl.parity_enable)
                 | (tc & ctrl.tc_irq_enable);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_frame_go;
        (tstate == TX_START) ##1 !tx_out;
    endsequence
    property p_frame_start;
        tx_load |=> s_frame_go;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("no low start bit");

    property p_idle_high;
        (tstate == TX_IDLE) && ten |=> tx_out;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line not high");

    // Pins follow the mode one edge later, so the check looks one cycle on
    property p_hd_drive;
        hd |=> !(tx_oe && tx_out);
    endproperty
    a_hd_drive: assert property (p_hd_drive) else $error("half-duplex drove high");

    property p_ck_hd;
        hd |=> !ck_oe && !ck_out;
    endproperty
    a_ck_hd: assert property (p_ck_hd) else $error("clock out in half-duplex");

    property p_pe_clear;
        wr_clr && pwdata[usf_pkg::CLR_PE] && !(rx_done && accept && par_bad) |=> !pe;
    endproperty
    a_pe_clear: assert property (p_pe_clear) else $error("parity flag not cleared");

    property p_tc_set;
        (tstate == TX_IDLE) && $past(tstate == TX_STOP) && $past(ten) && !$past(tdr_full)
            && !$past(wr_txd) |-> tc;
    endproperty
    a_tc_set: assert property (p_tc_set) else $error("complete flag missed");

    property p_load_empty;
        tx_load && !wr_txd |=> !tdr_full && (tstate == TX_START);
    endproperty
    a_load_empty: assert property (p_load_empty) else $error("buffer not drained");

    property p_lsb_first;
        (tstate == TX_DATA) && btick && ten |=> tsh == {1'b0, $past(tsh[8:1])};
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("shift not lsb first");

    property p_tx_parity;
        tx_load && ctrl.parity_enable |=> (^(tsh & mask(nbits))) == ctrl.parity_type;
    endproperty
    a_tx_parity: assert property (p_tx_parity) else $error("bad parity bit");
endmodule : usf_top

//--- dv/usart_frame_and_halfduplex_bench.sv
`timescale 1ns/1ps
module usart_frame_and_halfduplex_bench;
    logic        pclk, presetn, psel, penable, pwrite, half, err, ck_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic        pready, pslverr, tx_out, tx_oe, ck_out, ck_oe, irq, rx_pin, tx_pin_in;
    logic [11:0] got, f;
    logic [4:0]  c;
    int          fail_count, checks, ck_rises;

    usf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rx_pin(rx_pin),
        .tx_pin_in(tx_pin_in), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_out(tx_out), .tx_oe(tx_oe), .ck_out(ck_out), .ck_oe(ck_oe), .irq(irq));
    usf_partner #(.BIT(80)) u_partner (.pclk(pclk), .tx_out(tx_out), .tx_oe(tx_oe),
        .half(half), .rx_pin(rx_pin), .tx_pin_in(tx_pin_in));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic int width(input logic [4:0] k);
        return (k[3:2] == usf_pkg::WL_9) ? 9 : (k[3:2] == usf_pkg::WL_7) ? 7 : 8;
    endfunction : width

    // Frame bits from index 0: start, data with parity at top, stops
    function automatic logic [11:0] exp_frame(input logic [8:0] d, input logic [4:0] k);
        logic [8:0] x;
        int         n;
        n = width(k);
        x = d & 9'((1 << n) - 1);
        if (k[0]) x[n-1] = ^(x & 9'((1 << (n - 1)) - 1)) ^ k[1];
        return (12'(x) << 1) | (12'(k[4] ? 3 : 1) << (n + 1));
    endfunction : exp_frame

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Samples one transmitted frame at bit centres; h is half a bit in clocks
    task automatic capture(input logic [4:0] k, input int h);
        got = '0;
        for (int i = 0; i < 5000 && tx_out !== 1'b0; i++) @(posedge pclk);
        for (int i = 0; i < width(k) + 2 + k[4]; i++) begin
            repeat (i == 0 ? h : 2 * h) @(posedge pclk);
            got[i] = tx_out;
        end
    endtask : capture

    task automatic results;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Counts rising edges of the clock output
    always @(posedge pclk) begin
        ck_q <= ck_out;
        if (ck_out && !ck_q) ck_rises++;
    end

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        results();
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, half, paddr, pwdata} = '0;
        {fail_count, checks} = '0;
        seed = 32'h711F;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check(32'({tx_out, tx_oe, irq}), 32'h4);
        apb(1'b1, usf_pkg::OFF_BAUD, 32'h5);
        apb(1'b1, usf_pkg::OFF_CTRL, 32'h201);
        apb(1'b0, 8'h1C, 32'h0);
        check({rd[30:0], err}, 32'h1);
        check(32'({tx_out, tx_oe, ck_oe}), 32'h7);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            c = {seed[4], 2'(i % 3), seed[1:0]};
            apb(1'b1, usf_pkg::OFF_CTRL, 32'hA01 | (32'(c) << 2) | (32'(i[0]) << 7));
            ck_rises = 0;
            apb(1'b1, usf_pkg::OFF_TXD, 32'(seed[24:16]));
            apb(1'b1, usf_pkg::OFF_TXD, 32'(seed[8:0]));
            apb(1'b0, usf_pkg::OFF_STS, 32'h0);
            check(32'(rd[1]), 32'h0);
            capture(c, i[0] ? 20 : 40);
            check(32'(got), 32'(exp_frame(seed[24:16], c)));
            capture(c, i[0] ? 20 : 40);
            check(32'(got), 32'(exp_frame(seed[8:0], c)));
            repeat (200) @(posedge pclk);
            apb(1'b0, usf_pkg::OFF_STS, 32'h0);
            check(32'({rd[1], irq, tx_out}), 32'h7);
            check(32'(ck_rises), 32'(2 * width(c)));
        end
        $display("transmit frames done");
        apb(1'b1, usf_pkg::OFF_CTRL, 32'h407);
        f = exp_frame(9'h05A, 5'h01);
        u_partner.send(f ^ 12'h100, 10);
        repeat (100) @(posedge pclk);
        apb(1'b0, usf_pkg::OFF_STS, 32'h0);
        check(32'({rd[2], irq}), 32'h3);
        apb(1'b1, usf_pkg::OFF_CLR, 32'h1);
        apb(1'b0, usf_pkg::OFF_STS, 32'h0);
        check(32'({rd[2], irq}), 32'h0);
        u_partner.send(f, 10);
        repeat (100) @(posedge pclk);
        apb(1'b0, usf_pkg::OFF_STS, 32'h0);
        check(32'(rd[2]), 32'h0);
        $display("parity receive done");
        apb(1'b1, usf_pkg::OFF_CTRL, 32'h1003);
        apb(1'b1, usf_pkg::OFF_ADDR, 32'h3);
        u_partner.send(exp_frame(9'h085, 5'h0), 10);
        repeat (100) @(posedge pclk);
        apb(1'b0, usf_pkg::OFF_STS, 32'h0);
        check(32'(rd[6]), 32'h1);
        repeat (1000) @(posedge pclk);
        apb(1'b0, usf_pkg::OFF_STS, 32'h0);
        check(32'(rd[6]), 32'h0);
        $display("mute done");
        half <= 1'b1;
        apb(1'b1, usf_pkg::OFF_CTRL, 32'h101);
        apb(1'b0, usf_pkg::OFF_STS, 32'h0);
        if (rd[1] === 1'b1) apb(1'b1, usf_pkg::OFF_CTRL, 32'h103);
        check(32'({tx_oe, ck_oe}), 32'h0);
        u_partner.send(exp_frame(9'h0A5, 5'h0), 10);
        repeat (100) @(posedge pclk);
        apb(1'b0, usf_pkg::OFF_RXD, 32'h0);
        check(rd & 32'hFF, 32'hA5);
        $display("half duplex done");
        results();
    end
endmodule : usart_frame_and_halfduplex_bench

//--- dv/usf_partner.sv
`timescale 1ns/1ps
// ****************************************
// Far-side serial device
// ****************************************
module usf_partner #(
    parameter int BIT = 80
) (
    input  wire logic pclk,
    input  wire logic tx_out,
    input  wire logic tx_oe,
    input  wire logic half,
    output logic      rx_pin,
    output logic      tx_pin_in
);
    logic pull_low;

    // Shared wire with pull-up; either party may pull it low
    assign tx_pin_in = ~((tx_oe & ~tx_out) | pull_low);

    // Idle levels at time zero
    initial begin
        rx_pin   = 1'b1;
        pull_low = 1'b0;
    end

    // Sends one frame LSB first on the RX pin or onto the shared wire
    task automatic send(input logic [11:0] f, input int n);
        for (int k = 0; k < n; k++) begin
            pull_low <= half & ~f[k];
            rx_pin   <= half ? 1'b0 : f[k];
            repeat (BIT) @(posedge pclk);
        end
        pull_low <= 1'b0;
        rx_pin   <= ~half;
    endtask : send
endmodule : usf_partner
